// ---- verilog/oow_pkg.sv ----
// constants and carrier types for the orderwire overhead adaptation
package oow_pkg;
  localparam int OCTET_BITS = 8;
  // clock and bit timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BIT_PERIOD_PS = 15625000;
  localparam int BIT_CYCLES = BIT_PERIOD_PS / CLK_PERIOD_PS;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int TIMER_W = 12;
  // wander that the slip store must ride out
  localparam int WANDER_NS = 18000;
  localparam int WANDER_BITS = (WANDER_NS * 1000 + BIT_PERIOD_PS - 1) / BIT_PERIOD_PS;
  localparam int WANDER_OCTETS = (WANDER_BITS + OCTET_BITS - 1) / OCTET_BITS;
  localparam int SLIP_DEPTH = 4;
  localparam int SLIP_MIN_DEPTH = 2 + 2 * WANDER_OCTETS;
  // frame position
  localparam int POS_W = 16;
  localparam logic [15:0] E2_SLOT_DEFAULT = 16'h0010;
  // reset and substitute values, last bit index of an octet
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } oow_octet_t;
endpackage

// ---- verilog/oow_slip_store.sv ----
// octet slip store with write and read indices, read advanced by take and skip
`timescale 1ns/1ps
module oow_slip_store #(
  parameter int DEPTH = oow_pkg::SLIP_DEPTH,
  parameter int IDX_W = $clog2(DEPTH)
) (
  input wire logic mclk,
  input wire logic rst_n,
  input oow_pkg::oow_octet_t wr,
  input wire logic rd_take,
  input wire logic rd_skip,
  output logic [7:0] rd_data,
  output logic [IDX_W:0] fill
);
  // DEPTH must be a power of two so indices wrap by themselves
  logic [7:0] mem_r [DEPTH];
  logic [IDX_W-1:0] wr_idx_r;
  logic [IDX_W-1:0] rd_idx_r;
  logic [IDX_W:0] fill_r;
  logic wr_ok;
  logic [IDX_W:0] dec;

  assign wr_ok = wr.valid && (fill_r != (IDX_W+1)'(DEPTH));
  assign dec = rd_take ? (rd_skip ? (IDX_W+1)'(2) : (IDX_W+1)'(1)) : '0;
  assign rd_data = rd_skip ? mem_r[IDX_W'(rd_idx_r + 1'b1)] : mem_r[rd_idx_r];
  assign fill = fill_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= oow_pkg::ALL_ONES;
      end
    end else if (wr_ok) begin
      mem_r[wr_idx_r] <= wr.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx_r <= '0;
      rd_idx_r <= '0;
      fill_r <= '0;
    end else begin
      if (wr_ok) begin
        wr_idx_r <= IDX_W'(wr_idx_r + 1'b1);
      end
      rd_idx_r <= IDX_W'(rd_idx_r + dec[IDX_W-1:0]);
      fill_r <= (IDX_W+1)'(fill_r + {{IDX_W{1'b0}}, wr_ok} - dec);
    end
  end

  fill_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fill_r <= (IDX_W+1)'(DEPTH)) else $error("slip store fill beyond depth");
  skip_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_take && rd_skip && !wr_ok |=> fill_r == $past(fill_r) - (IDX_W+1)'(2))
    else $error("positive slip did not drop one octet");
endmodule // oow_slip_store

// ---- verilog/oow_sink_serial.sv ----
// sink holding store and 64 kbit/s serialiser with all-ones substitution
`timescale 1ns/1ps
module oow_sink_serial #(
  parameter int BIT_CYCLES = oow_pkg::BIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input oow_pkg::oow_octet_t octet_in,
  input wire logic fail,
  output logic ser_data,
  output logic ser_clk
);
  logic [7:0] hold_r;
  logic [7:0] shreg_r;
  logic [oow_pkg::TIMER_W-1:0] timer_r;
  logic [2:0] bit_idx_r;
  logic ser_data_r;
  logic ser_clk_r;
  logic tick;
  logic load;
  logic [7:0] load_val;

  assign tick = timer_r == oow_pkg::TIMER_W'(BIT_CYCLES - 1);
  assign load = tick && (bit_idx_r == 3'h0);
  assign load_val = fail ? oow_pkg::ALL_ONES : hold_r;
  assign ser_data = ser_data_r;
  assign ser_clk = ser_clk_r;

  // ****************************************
  // holding store
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= oow_pkg::ALL_ONES;
    end else if (octet_in.valid) begin
      hold_r <= octet_in.data;
    end
  end

  // ****************************************
  // bit timer, nominal 64 kHz
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= '0;
      ser_clk_r <= 1'b0;
    end else begin
      timer_r <= tick ? '0 : oow_pkg::TIMER_W'(timer_r + 1'b1);
      ser_clk_r <= timer_r < oow_pkg::TIMER_W'(BIT_CYCLES / 2);
    end
  end

  // ****************************************
  // shifter, msb first
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shreg_r <= oow_pkg::ALL_ONES;
      bit_idx_r <= '0;
      ser_data_r <= 1'b1;
    end else if (tick) begin
      bit_idx_r <= 3'(bit_idx_r + 1'b1);
      if (load) begin
        ser_data_r <= load_val[7];
        shreg_r <= {load_val[6:0], 1'b1};
      end else begin
        ser_data_r <= shreg_r[7];
        shreg_r <= {shreg_r[6:0], 1'b1};
      end
    end
  end

  logic [oow_pkg::TIMER_W-1:0] gap_r;
  logic seen_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= tick ? '0 : oow_pkg::TIMER_W'(gap_r + 1'b1);
      seen_r <= seen_r | tick;
    end
  end

  bit_period_a: assert property (@(posedge mclk) disable iff (!rst_n)
    tick && seen_r |-> gap_r == oow_pkg::TIMER_W'(BIT_CYCLES - 1))
    else $error("serial bit period wrong");
  ones_subst_a: assert property (@(posedge mclk) disable iff (!rst_n)
    load && fail |=> ser_data_r && shreg_r == oow_pkg::ALL_ONES)
    else $error("all-ones not substituted");
  data_resume_a: assert property (@(posedge mclk) disable iff (!rst_n)
    load && !fail |=> ser_data_r == $past(hold_r[7]))
    else $error("extracted data not resumed");
endmodule // oow_sink_serial

// ---- verilog/oow_adapt.sv ----
// orderwire to E2 overhead adaptation, source and sink
// Contract
// - the source places the 64 kbit/s octet stream into the E2 byte of each outgoing frame.
// - the source writes incoming orderwire bits into a slip store on the orderwire clock.
// - the source reads octets on the line clock, frame position and its own slip decisions.
// - on a positive slip the source skips reading one whole octet exactly once.
// - on a negative slip the source sends the same octet a second time.
// - the slip store holds at least 18 us of wander without corrupting data.
// - the sink extracts the orderwire octet from the E2 byte of each received frame.
// - the sink latches each received octet into a holding store on the section clock.
// - the sink shifts the eight bits out serially on a nominal 64 kHz clock.
// - when trail signal fail asserts the sink sends all-ONEs within 1 ms.
// - when trail signal fail clears the sink resumes extracted data within 1 ms.
// - while substituting all-ONEs the sink keeps 64 kbit/s within 100 ppm.
`timescale 1ns/1ps
module oow_adapt #(
  parameter logic [15:0] E2_SLOT = oow_pkg::E2_SLOT_DEFAULT,
  parameter int SLIP_DEPTH = oow_pkg::SLIP_DEPTH,
  parameter int BIT_CYCLES = oow_pkg::BIT_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  // source, orderwire side
  input wire logic orderwire_data,
  input wire logic orderwire_clock,
  input wire logic orderwire_octet_sync,
  // source, line side
  input wire logic line_timing_clock,
  input wire logic line_timing_frame_start,
  output logic [7:0] section_e2_data,
  output logic section_e2_valid,
  output logic slip_positive,
  output logic slip_negative,
  // sink, section side
  input wire logic [7:0] section_data,
  input wire logic section_clock,
  input wire logic section_frame_start,
  input wire logic trail_signal_fail_in,
  // sink, orderwire side
  output logic orderwire_sink_data,
  output logic orderwire_sink_clock,
  output logic orderwire_signal_fail_out
);
  localparam int IDX_W = $clog2(SLIP_DEPTH);
  localparam logic [IDX_W:0] SLIP_HIGH = (IDX_W+1)'(SLIP_DEPTH - 1);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // next byte position within a frame
  function automatic logic [15:0] next_pos(input logic fs, input logic [15:0] pos);
    next_pos = fs ? 16'h0000 : 16'(pos + 1'b1);
  endfunction

  // ****************************************
  // source: bit capture
  // ****************************************
  logic ow_clk_d_r;
  logic ow_rise;
  logic [6:0] ow_shift_r;
  logic [2:0] ow_bit_r;
  logic [2:0] ow_bit_cur;
  oow_pkg::oow_octet_t wr_r;

  assign ow_rise = orderwire_clock && !ow_clk_d_r;
  assign ow_bit_cur = orderwire_octet_sync ? 3'h0 : ow_bit_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ow_clk_d_r <= 1'b0;
    end else begin
      ow_clk_d_r <= orderwire_clock;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ow_shift_r <= '0;
    end else if (ow_rise) begin
      ow_shift_r <= {ow_shift_r[5:0], orderwire_data};
    end
  end

  // bit counter, realigned by the octet sync
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ow_bit_r <= '0;
    end else if (ow_rise) begin
      ow_bit_r <= 3'(ow_bit_cur + 1'b1);
    end
  end

  // eighth bit completes the octet, one-cycle write request
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= '{data: oow_pkg::ALL_ONES, valid: 1'b0};
    end else if (ow_rise && (ow_bit_cur == oow_pkg::LAST_BIT)) begin
      wr_r <= '{data: {ow_shift_r, orderwire_data}, valid: 1'b1};
    end else begin
      wr_r.valid <= 1'b0;
    end
  end

  // ****************************************
  // source: frame position and slip decision
  // ****************************************
  logic [15:0] src_pos_r;
  logic src_slot;
  logic [7:0] rd_data;
  logic [IDX_W:0] fill;
  logic rd_take;
  logic rd_skip;

  assign src_slot = line_timing_clock &&
                    (next_pos(line_timing_frame_start, src_pos_r) == E2_SLOT);
  // decisions fall only on whole octets, once per frame
  assign rd_take = src_slot && (fill != '0);
  assign rd_skip = src_slot && (fill >= SLIP_HIGH);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      src_pos_r <= '0;
    end else if (line_timing_clock) begin
      src_pos_r <= next_pos(line_timing_frame_start, src_pos_r);
    end
  end

  oow_slip_store #(.DEPTH(SLIP_DEPTH), .IDX_W(IDX_W)) u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(wr_r),
    .rd_take(rd_take),
    .rd_skip(rd_skip),
    .rd_data(rd_data),
    .fill(fill)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      section_e2_data <= oow_pkg::ALL_ONES;
    end else if (rd_take) begin
      section_e2_data <= rd_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      section_e2_valid <= 1'b0;
    end else begin
      section_e2_valid <= src_slot;
    end
  end

  // slip indications, pulse together with the slot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slip_positive <= 1'b0;
    end else begin
      slip_positive <= rd_skip;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slip_negative <= 1'b0;
    end else begin
      slip_negative <= src_slot && !rd_take;
    end
  end

  // ****************************************
  // sink: E2 extraction
  // ****************************************
  logic [15:0] snk_pos_r;
  oow_pkg::oow_octet_t snk_octet_r;
  logic snk_slot;

  assign snk_slot = section_clock && (next_pos(section_frame_start, snk_pos_r) == E2_SLOT);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snk_pos_r <= '0;
    end else if (section_clock) begin
      snk_pos_r <= next_pos(section_frame_start, snk_pos_r);
    end
  end

  // E2 octet with a one-cycle valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snk_octet_r <= '{data: oow_pkg::ALL_ONES, valid: 1'b0};
    end else begin
      snk_octet_r <= '{data: section_data, valid: snk_slot};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      orderwire_signal_fail_out <= 1'b0;
    end else begin
      orderwire_signal_fail_out <= trail_signal_fail_in;
    end
  end

  oow_sink_serial #(.BIT_CYCLES(BIT_CYCLES)) u_serial (
    .mclk(mclk),
    .rst_n(rst_n),
    .octet_in(snk_octet_r),
    .fail(trail_signal_fail_in),
    .ser_data(orderwire_sink_data),
    .ser_clk(orderwire_sink_clock)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence src_slot_s;
    src_slot && (fill != '0);
  endsequence
  sequence e2_out_s(logic [7:0] d);
    section_e2_valid && (section_e2_data == d);
  endsequence

  e2_insert_a: assert property (@(posedge mclk) disable iff (!rst_n)
    src_slot_s |=> e2_out_s($past(rd_data)))
    else $error("E2 octet not taken from slip store");
  octet_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ow_rise && ow_bit_cur == oow_pkg::LAST_BIT |=> wr_r.valid && wr_r.data[0] == $past(orderwire_data))
    else $error("orderwire octet not written");
  read_slot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    section_e2_valid |-> $past(line_timing_clock) && ($past(line_timing_frame_start) ?
      (E2_SLOT == 16'h0000) : ($past(src_pos_r) == 16'(E2_SLOT - 1'b1))))
    else $error("E2 emitted off its slot");
  repeat_octet_a: assert property (@(posedge mclk) disable iff (!rst_n)
    slip_negative |-> section_e2_valid && section_e2_data == $past(section_e2_data))
    else $error("negative slip did not repeat octet");
  slip_at_slot_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (slip_positive || slip_negative) |-> section_e2_valid && !(slip_positive && slip_negative))
    else $error("slip decided off octet slot");
  sink_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    snk_slot |=> snk_octet_r.valid && snk_octet_r.data == $past(section_data))
    else $error("E2 octet not extracted");
  fail_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> orderwire_signal_fail_out == $past(trail_signal_fail_in))
    else $error("signal fail output not direct");
  depth_min_a: assert property (@(posedge mclk) disable iff (!rst_n)
    SLIP_DEPTH >= oow_pkg::SLIP_MIN_DEPTH)
    else $error("slip store too shallow for wander");

  // slip decisions, frame tracking and octet alignment
  sequence pos_slip_s;
    src_slot && (fill >= SLIP_HIGH);
  endsequence
  sequence neg_slip_s;
    src_slot && (fill == '0);
  endsequence

  pos_slip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pos_slip_s |=> slip_positive && section_e2_valid && section_e2_data == $past(rd_data))
    else $error("positive slip not reported");
  skip_fill_a: assert property (@(posedge mclk) disable iff (!rst_n)
    slip_positive |-> $past(fill) >= SLIP_HIGH)
    else $error("positive slip without high fill");
  neg_slip_a: assert property (@(posedge mclk) disable iff (!rst_n)
    neg_slip_s |=> slip_negative && !slip_positive && $stable(section_e2_data))
    else $error("negative slip not reported");
  take_fill_a: assert property (@(posedge mclk) disable iff (!rst_n)
    src_slot && (fill != '0) && (fill < SLIP_HIGH) |=> !slip_positive && !slip_negative)
    else $error("slip decided with fill in range");
  e2_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd_take |=> $stable(section_e2_data))
    else $error("E2 octet changed off its slot");
  src_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
    line_timing_clock && line_timing_frame_start |=> src_pos_r == 16'h0000)
    else $error("line frame position not restarted");
  snk_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
    section_clock && section_frame_start |=> snk_pos_r == 16'h0000)
    else $error("section frame position not restarted");
  sink_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !snk_slot |=> !snk_octet_r.valid)
    else $error("E2 octet taken off its slot");
  octet_sync_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ow_rise && orderwire_octet_sync |=> ow_bit_r == 3'h1)
    else $error("orderwire octet not realigned");
  octet_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_r.valid |-> $past(ow_rise) && $past(ow_bit_cur) == oow_pkg::LAST_BIT)
    else $error("octet written before eight bits");
endmodule // oow_adapt

// ---- tb/oow_far_model.sv ----
// far-end model: orderwire source, line timing and received frames
`timescale 1ns/1ps
module oow_far_model #(
  parameter int FRAME_BYTES = 24,
  parameter int E2_POS = 16
) (
  input wire logic mclk,
  output logic orderwire_data,
  output logic orderwire_clock,
  output logic orderwire_octet_sync,
  output logic line_timing_clock,
  output logic line_timing_frame_start,
  output logic [7:0] section_data,
  output logic section_clock,
  output logic section_frame_start
);
  initial begin
    orderwire_data = 1'b0;
    orderwire_clock = 1'b0;
    orderwire_octet_sync = 1'b0;
    line_timing_clock = 1'b0;
    line_timing_frame_start = 1'b0;
    section_data = 8'h00;
    section_clock = 1'b0;
    section_frame_start = 1'b0;
  end
  // *****
  // orderwire bits, msb first; clock idles low between octets
  // *****
  task automatic ow_send(input logic [7:0] v, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      @(negedge mclk);
      orderwire_data = v[7 - i];
      orderwire_clock = 1'b1;
      orderwire_octet_sync = (nbits == 8 && i == 0);
      repeat (2) @(negedge mclk);
      orderwire_clock = 1'b0;
      orderwire_octet_sync = 1'b0;
      orderwire_data = ~orderwire_data;
      @(negedge mclk);
    end
  endtask
  // *****
  // one frame of line timing strobes or received bytes
  // *****
  task automatic frame(input logic line, input logic [7:0] e2);
    for (int p = 0; p < FRAME_BYTES; p++) begin
      @(negedge mclk);
      line_timing_clock = line;
      line_timing_frame_start = line && (p == 0);
      section_clock = !line;
      section_frame_start = !line && (p == 0);
      section_data = (p == E2_POS) ? e2 : (8'(p) ^ 8'hA5);
      @(negedge mclk);
      line_timing_clock = 1'b0;
      line_timing_frame_start = 1'b0;
      section_clock = 1'b0;
      section_frame_start = 1'b0;
      section_data = ~section_data;
    end
  endtask
endmodule // oow_far_model

// ---- tb/tb_orderwire_overhead_adaptation.sv ----
// self-checking bench for the orderwire overhead adaptation
`timescale 1ns/1ps
module tb_orderwire_overhead_adaptation;
  localparam int BITC = 40;
  localparam int LIMIT = 10000;
  logic mclk, reset_n, ow_d, ow_c, ow_s, lt_c, lt_fs, sec_c, sec_fs, trail_signal_fail_in;
  logic [7:0] sec_d, section_e2_data;
  logic section_e2_valid, slip_positive, slip_negative;
  logic orderwire_sink_data, orderwire_sink_clock, orderwire_signal_fail_out;
  logic [9:0] src_q[$];
  logic [7:0] sval [2] = '{8'h1D, 8'hB2};
  logic sck_d = 1'b0;
  logic armed = 1'b0;
  int per_cnt = 0;
  int cyc = 0;
  int err_total = 0;
  int tests_run = 0;

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  oow_far_model i_far (.mclk(mclk), .orderwire_data(ow_d), .orderwire_clock(ow_c),
    .orderwire_octet_sync(ow_s), .line_timing_clock(lt_c), .line_timing_frame_start(lt_fs),
    .section_data(sec_d), .section_clock(sec_c), .section_frame_start(sec_fs));

  oow_adapt #(.BIT_CYCLES(BITC)) i_dut (.mclk(mclk), .reset_n(reset_n),
    .orderwire_data(ow_d), .orderwire_clock(ow_c), .orderwire_octet_sync(ow_s),
    .line_timing_clock(lt_c), .line_timing_frame_start(lt_fs),
    .section_e2_data(section_e2_data), .section_e2_valid(section_e2_valid),
    .slip_positive(slip_positive), .slip_negative(slip_negative),
    .section_data(sec_d), .section_clock(sec_c), .section_frame_start(sec_fs),
    .trail_signal_fail_in(trail_signal_fail_in), .orderwire_sink_data(orderwire_sink_data),
    .orderwire_sink_clock(orderwire_sink_clock),
    .orderwire_signal_fail_out(orderwire_signal_fail_out));

  // *****
  // monitors: e2 slot capture, sink bit period, hang limit
  // *****
  always @(posedge mclk) begin
    if (section_e2_valid === 1'b1) begin
      src_q.push_back({slip_positive, slip_negative, section_e2_data});
    end
  end

  always @(posedge mclk) begin
    sck_d <= orderwire_sink_clock;
    per_cnt <= per_cnt + 1;
    if (orderwire_sink_clock === 1'b1 && sck_d === 1'b0) begin
      if (armed) begin
        check("sink bit period", BITC, per_cnt);
      end
      armed <= 1'b1;
      per_cnt <= 1;
    end
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      end_sim();
    end
  end

  // *****
  // shared helpers
  // *****
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic rot_ok(input logic [7:0] v, input logic [7:0] g);
    logic [15:0] w;
    w = {v, v};
    rot_ok = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (w[i +: 8] === g) rot_ok = 1'b1;
    end
  endfunction

  task automatic src_expect(input logic pos, input logic neg, input logic [7:0] d);
    i_far.frame(1'b1, 8'h00);
    repeat (2) @(negedge mclk);
    check("e2 slot count", 1, src_q.size());
    if (src_q.size() > 0) begin
      check("e2 slot", {pos, neg, d}, src_q.pop_front());
    end
  endtask

  task automatic get_bits(input int skip, output logic [7:0] b);
    b = 8'h00;
    repeat (skip) @(negedge orderwire_sink_clock);
    for (int i = 0; i < 8; i++) begin
      @(negedge orderwire_sink_clock);
      b = {b[6:0], orderwire_sink_data};
    end
  endtask

  // *****
  // scenarios
  // *****
  task automatic t_source();
    src_expect(1'b0, 1'b1, 8'hFF);
    i_far.ow_send(8'h11, 8);
    i_far.ow_send(8'h22, 8);
    src_expect(1'b0, 1'b0, 8'h11);
    src_expect(1'b0, 1'b0, 8'h22);
    src_expect(1'b0, 1'b1, 8'h22);
  endtask

  task automatic t_slip();
    check("slip depth", 1, oow_pkg::SLIP_DEPTH >= oow_pkg::SLIP_MIN_DEPTH);
    i_far.ow_send(8'h99, 3);
    i_far.ow_send(8'h33, 8);
    i_far.ow_send(8'h44, 8);
    i_far.ow_send(8'h55, 8);
    src_expect(1'b1, 1'b0, 8'h44);
    src_expect(1'b0, 1'b0, 8'h55);
    src_expect(1'b0, 1'b1, 8'h55);
  endtask

  task automatic t_sink();
    logic [7:0] b;
    for (int k = 0; k < 2; k++) begin
      i_far.frame(1'b0, sval[k]);
      get_bits(9, b);
      check("sink octet", 1, rot_ok(sval[k], b));
    end
  endtask

  task automatic t_fail();
    logic [7:0] b;
    @(negedge mclk);
    trail_signal_fail_in = 1'b1;
    @(negedge mclk);
    check("fail out", 1, orderwire_signal_fail_out);
    get_bits(9, b);
    check("substitute octet", 8'hFF, b);
    @(negedge mclk);
    trail_signal_fail_in = 1'b0;
    @(negedge mclk);
    check("fail out", 0, orderwire_signal_fail_out);
    get_bits(9, b);
    check("resumed octet", 1, rot_ok(sval[1], b));
  endtask

  task automatic end_sim();
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    trail_signal_fail_in = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_source();
    t_slip();
    t_sink();
    t_fail();
    end_sim();
  end
endmodule // tb_orderwire_overhead_adaptation
